/* include/thermal_event_pkg.sv */
// constants shared by the thermal event monitor
package thermal_event_pkg;

  // ---------------------------------------------------------------
  // register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_CAPABILITY = 8'h00;
  localparam logic [7:0] PTR_SETUP      = 8'h01;
  localparam logic [7:0] PTR_HIGH       = 8'h02;
  localparam logic [7:0] PTR_LOW        = 8'h03;
  localparam logic [7:0] PTR_ALARM      = 8'h04;
  localparam logic [7:0] PTR_PRECISION  = 8'h08;

  // ---------------------------------------------------------------
  // setup and capability word field positions
  // ---------------------------------------------------------------
  localparam int SET_MODE_BIT   = 0;
  localparam int SET_POL_BIT    = 1;
  localparam int SET_ALARM_BIT  = 2;
  localparam int SET_EN_BIT     = 3;
  localparam int SET_STAT_BIT   = 4;
  localparam int SET_CLR_BIT    = 5;
  localparam int SET_LOCKA_BIT  = 6;
  localparam int SET_LOCKB_BIT  = 7;
  localparam int SET_SD_BIT     = 8;
  localparam int SET_HYST_LSB   = 9;
  localparam int CAP_PREC_LSB   = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SETUP_RESET     = 16'h0000;
  localparam logic [1:0]  PRECISION_RESET = 2'h1;
  localparam logic [12:0] LIMIT_RESET     = 13'h0000;
  localparam logic [15:0] CAP_BASE        = 16'h0000;

  // hysteresis in sixteenths of a degree: 0, 1.5, 3, 6
  localparam logic [12:0] HYST_0 = 13'h0000;
  localparam logic [12:0] HYST_1 = 13'h0018;
  localparam logic [12:0] HYST_2 = 13'h0030;
  localparam logic [12:0] HYST_3 = 13'h0060;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int PERIOD_MS_P0 = 30;
  localparam int PERIOD_MS_P1 = 65;
  localparam int PERIOD_MS_P2 = 130;
  localparam int PERIOD_MS_P3 = 260;
  localparam int PERIOD_CYC_P0 = PERIOD_MS_P0 * (CLK_HZ / 1000);
  localparam int PERIOD_CYC_P1 = PERIOD_MS_P1 * (CLK_HZ / 1000);
  localparam int PERIOD_CYC_P2 = PERIOD_MS_P2 * (CLK_HZ / 1000);
  localparam int PERIOD_CYC_P3 = PERIOD_MS_P3 * (CLK_HZ / 1000);
  localparam int CNT_W         = 24;

  typedef enum logic {CONV_RUN, CONV_HALT} conv_state_t;

endpackage

/* src/thermal_event_monitor.sv */
// thermal event monitor: conversion pacing, limits and event output
`timescale 1ns/1ps
module thermal_event_monitor #(
  parameter int PERIOD_P0 = thermal_event_pkg::PERIOD_CYC_P0,
  parameter int PERIOD_P1 = thermal_event_pkg::PERIOD_CYC_P1,
  parameter int PERIOD_P2 = thermal_event_pkg::PERIOD_CYC_P2,
  parameter int PERIOD_P3 = thermal_event_pkg::PERIOD_CYC_P3
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_ptr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic [12:0] ambient_i,
  output logic      [15:0] reg_rdata_o,
  output logic             event_o,
  output logic             sensing_on_o,
  output logic             sample_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    thermal_event_pkg::conv_state_t st;
    logic [thermal_event_pkg::CNT_W-1:0] cnt;
    logic [1:0]  prec;
    logic        mode;
    logic        pol;
    logic        alarm_only;
    logic        ev_en;
    logic        lock_a;
    logic        lock_b;
    logic [1:0]  hyst;
    logic [12:0] high;
    logic [12:0] low;
    logic [12:0] alarm;
    logic        high_up;
    logic        low_dn;
    logic        alarm_up;
    logic        irq;
    logic        active;
    logic        event_lvl;
    logic        sensing;
    logic        sample;
    logic [15:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   rst_meta_q;
  logic   rst_sync_q;
  logic   setup_wr;
  logic   locked;
  logic   sample;
  logic   clr;
  logic   win_now;
  logic   win_prev;
  logic signed [13:0] amb;
  logic signed [13:0] hyst_v;

  // conversion period reload, one less than the period in cycles
  function automatic logic [thermal_event_pkg::CNT_W-1:0] reload(
    input logic [1:0] p
  );
    int c;
    c = PERIOD_P0;
    case (p)
      2'h1:    c = PERIOD_P1;
      2'h2:    c = PERIOD_P2;
      2'h3:    c = PERIOD_P3;
      default: c = PERIOD_P0;
    endcase
    return thermal_event_pkg::CNT_W'(c - 1);
  endfunction

  function automatic logic signed [13:0] sx(input logic [12:0] v);
    return $signed({v[12], v});
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign setup_wr = reg_wr_i && (reg_ptr_i == thermal_event_pkg::PTR_SETUP);
  assign locked   = s_q.lock_a | s_q.lock_b;
  assign sample   = (s_q.st == thermal_event_pkg::CONV_RUN) &&
                    (s_q.cnt == '0);
  assign clr      = setup_wr && reg_wdata_i[thermal_event_pkg::SET_CLR_BIT];
  assign amb      = sx(ambient_i);
  assign win_prev = s_q.high_up | s_q.low_dn;

  always_comb
  begin
    s_d = s_q;
    case (s_q.hyst)
      2'h1:    hyst_v = sx(thermal_event_pkg::HYST_1);
      2'h2:    hyst_v = sx(thermal_event_pkg::HYST_2);
      2'h3:    hyst_v = sx(thermal_event_pkg::HYST_3);
      default: hyst_v = sx(thermal_event_pkg::HYST_0);
    endcase
    // writes are honoured in every state, shutdown included
    if (reg_wr_i)
    begin
      case (reg_ptr_i)
        thermal_event_pkg::PTR_SETUP:
        begin
          s_d.alarm_only = reg_wdata_i[thermal_event_pkg::SET_ALARM_BIT];
          // interrupt mode is not selectable in alarm-only
          s_d.mode  = reg_wdata_i[thermal_event_pkg::SET_MODE_BIT] &
                      ~reg_wdata_i[thermal_event_pkg::SET_ALARM_BIT];
          s_d.pol   = reg_wdata_i[thermal_event_pkg::SET_POL_BIT];
          s_d.ev_en = reg_wdata_i[thermal_event_pkg::SET_EN_BIT];
          // locks are sticky until reset so a stray write cannot undo them
          s_d.lock_a = s_q.lock_a |
                       reg_wdata_i[thermal_event_pkg::SET_LOCKA_BIT];
          s_d.lock_b = s_q.lock_b |
                       reg_wdata_i[thermal_event_pkg::SET_LOCKB_BIT];
          s_d.hyst  = reg_wdata_i[thermal_event_pkg::SET_HYST_LSB +: 2];
          if (!reg_wdata_i[thermal_event_pkg::SET_SD_BIT])
            s_d.st = thermal_event_pkg::CONV_RUN;
          else if (!locked)
            s_d.st = thermal_event_pkg::CONV_HALT;
        end
        thermal_event_pkg::PTR_HIGH:
          if (!locked)
            s_d.high = {reg_wdata_i[12:2], 2'h0};
        thermal_event_pkg::PTR_LOW:
          if (!locked)
            s_d.low = {reg_wdata_i[12:2], 2'h0};
        thermal_event_pkg::PTR_ALARM:
          if (!locked)
            s_d.alarm = {reg_wdata_i[12:2], 2'h0};
        thermal_event_pkg::PTR_PRECISION:
          s_d.prec = reg_wdata_i[1:0];
        default:
          s_d.prec = s_d.prec;
      endcase
    end

    // conversion pacing; nothing counts while halted
    if (sample)
      s_d.cnt = reload(s_q.prec);
    else if (s_q.st == thermal_event_pkg::CONV_RUN)
      s_d.cnt = s_q.cnt - 1'b1;
    // a restart waits a full period before the first judgement
    if (s_q.st == thermal_event_pkg::CONV_HALT &&
        s_d.st == thermal_event_pkg::CONV_RUN)
      s_d.cnt = reload(s_d.prec);

    // limit flags only move on a fresh reading
    if (sample)
    begin
      if (amb > sx(s_q.high))
        s_d.high_up = 1'b1;
      else if (amb < sx(s_q.high) - hyst_v)
        s_d.high_up = 1'b0;
      if (amb < sx(s_q.low) - hyst_v)
        s_d.low_dn = 1'b1;
      else if (amb >= sx(s_q.low))
        s_d.low_dn = 1'b0;
      if (amb >= sx(s_q.alarm))
        s_d.alarm_up = 1'b1;
      else if (amb < sx(s_q.alarm) - hyst_v)
        s_d.alarm_up = 1'b0;
    end
    win_now = s_d.high_up | s_d.low_dn;

    // clear strobe first, so a crossing in the same cycle wins
    if (clr)
      s_d.irq = 1'b0;
    if (sample && win_now && !win_prev)
      s_d.irq = 1'b1;

    s_d.active = s_d.ev_en & (s_d.alarm_up |
                 (~s_d.alarm_only &
                  (s_d.mode ? s_d.irq : win_now)));
    s_d.event_lvl = s_d.active ^ ~s_d.pol;
    s_d.sensing   = (s_d.st == thermal_event_pkg::CONV_RUN);
    s_d.sample    = sample;

    case (reg_ptr_i)
      thermal_event_pkg::PTR_CAPABILITY:
      begin
        s_d.rdata = thermal_event_pkg::CAP_BASE;
        s_d.rdata[thermal_event_pkg::CAP_PREC_LSB +: 2] = s_q.prec;
      end
      thermal_event_pkg::PTR_SETUP:
        s_d.rdata = {5'h00, s_q.hyst,
                     s_q.st == thermal_event_pkg::CONV_HALT,
                     s_q.lock_b, s_q.lock_a, 1'b0,
                     s_q.active,
                     s_q.ev_en, s_q.alarm_only, s_q.pol, s_q.mode};
      thermal_event_pkg::PTR_HIGH:      s_d.rdata = {3'h0, s_q.high};
      thermal_event_pkg::PTR_LOW:       s_d.rdata = {3'h0, s_q.low};
      thermal_event_pkg::PTR_ALARM:     s_d.rdata = {3'h0, s_q.alarm};
      thermal_event_pkg::PTR_PRECISION: s_d.rdata = {14'h0000, s_q.prec};
      default:                          s_d.rdata = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q            <= '0;
      s_q.st         <= thermal_event_pkg::CONV_RUN;
      s_q.cnt        <= reload(thermal_event_pkg::PRECISION_RESET);
      s_q.prec       <= thermal_event_pkg::PRECISION_RESET;
      s_q.mode       <= thermal_event_pkg::SETUP_RESET[0];
      s_q.pol        <= thermal_event_pkg::SETUP_RESET[1];
      s_q.high       <= thermal_event_pkg::LIMIT_RESET;
      s_q.low        <= thermal_event_pkg::LIMIT_RESET;
      s_q.alarm      <= thermal_event_pkg::LIMIT_RESET;
      s_q.event_lvl  <= 1'b1;
      s_q.sensing    <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata_o  = s_q.rdata;
  assign event_o      = s_q.event_lvl;
  assign sensing_on_o = s_q.sensing;
  assign sample_o     = s_q.sample;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_sync_q);

  sequence s_setup_wr;
    reg_wr_i && reg_ptr_i == thermal_event_pkg::PTR_SETUP;
  endsequence
  sequence s_sd_request;
    s_setup_wr ##0 reg_wdata_i[thermal_event_pkg::SET_SD_BIT];
  endsequence

  a_sd_enter: assert property (
    s_sd_request ##0 !locked |=> !sensing_on_o ##1 !sample_o[*4])
    else $error("shutdown request not honoured");
  a_sd_locked: assert property (
    s_sd_request ##0 locked ##0 sensing_on_o |=> sensing_on_o)
    else $error("shutdown taken while locked");
  a_sd_hold: assert property (
    s_q.st == thermal_event_pkg::CONV_HALT && !setup_wr |=>
      s_q.st == thermal_event_pkg::CONV_HALT)
    else $error("shutdown left without a write");
  a_sd_exit: assert property (
    s_setup_wr ##0 !reg_wdata_i[thermal_event_pkg::SET_SD_BIT] |=>
      sensing_on_o)
    else $error("shutdown not cleared");
  a_halt_event: assert property (
    (s_q.st == thermal_event_pkg::CONV_HALT && !setup_wr) [*2] |->
      $stable(event_o))
    else $error("event moved during shutdown");
  a_limit_lock: assert property (
    reg_wr_i && locked && reg_ptr_i == thermal_event_pkg::PTR_HIGH |=>
      $stable(s_q.high))
    else $error("locked limit was written");
  a_event_off: assert property (
    !s_q.ev_en && !setup_wr |=> event_o == !s_q.pol)
    else $error("disabled event asserted");
  a_status_read: assert property (
    reg_ptr_i == thermal_event_pkg::PTR_SETUP |=>
      reg_rdata_o[thermal_event_pkg::SET_STAT_BIT] == $past(s_q.active))
    else $error("status bit wrong");
  a_prec_mirror: assert property (
    reg_ptr_i == thermal_event_pkg::PTR_CAPABILITY |=>
      reg_rdata_o[4:3] == $past(s_q.prec))
    else $error("capability precision wrong");
  a_irq_clear: assert property (
    clr && !sample |=> !s_q.irq)
    else $error("interrupt not cleared");
  a_alarm_force: assert property (
    s_q.alarm_up && s_q.ev_en |-> s_q.active)
    else $error("alarm did not force event");
  a_period_load: assert property (
    sample |=> s_q.cnt == reload($past(s_q.prec)))
    else $error("conversion period reload wrong");

endmodule

/* tb/host_model.sv */
// host-side register access model for the thermal event monitor
`timescale 1ns/1ps
module host_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [7:0]  reg_ptr_o,
  output logic             reg_wr_o,
  output logic      [15:0] reg_wdata_o
);
  // ---------------------------------------------------------------
  // idle state
  // ---------------------------------------------------------------
  initial
  begin
    reg_ptr_o   = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // ---------------------------------------------------------------
  // access tasks, entered and left at a falling edge
  // ---------------------------------------------------------------
  // strobe covers exactly one rising edge; an idle cycle follows so a
  // back-to-back call never lowers and raises it in one time step
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    reg_ptr_o   = p;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge mclk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
    @(negedge mclk_i);
  endtask

  // read data is registered from the pointer one edge earlier
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    reg_ptr_o = p;
    @(negedge mclk_i);
    d = rdata_i;
  endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the thermal event monitor
`timescale 1ns/1ps
module tb_top;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  reg_ptr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic [12:0] ambient;
  logic [15:0] reg_rdata;
  logic        evt;
  logic        sensing_on;
  logic        sample;
  int          err_total;
  int          compares;
  int          cnt;
  int          per[4] = '{20, 30, 40, 50};

  // ---------------------------------------------------------------
  // design and host
  // ---------------------------------------------------------------
  thermal_event_monitor #(
    .PERIOD_P0 (20),
    .PERIOD_P1 (30),
    .PERIOD_P2 (40),
    .PERIOD_P3 (50)
  ) u_thermal_event_monitor (
    .mclk_i       (mclk),
    .rst_n_i      (rst_n),
    .reg_ptr_i    (reg_ptr),
    .reg_wr_i     (reg_wr),
    .reg_wdata_i  (reg_wdata),
    .ambient_i    (ambient),
    .reg_rdata_o  (reg_rdata),
    .event_o      (evt),
    .sensing_on_o (sensing_on),
    .sample_o     (sample)
  );

  host_model u_host_model (
    .mclk_i      (mclk),
    .rdata_i     (reg_rdata),
    .reg_ptr_o   (reg_ptr),
    .reg_wr_o    (reg_wr),
    .reg_wdata_o (reg_wdata)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
    logic [15:0] v;
    u_host_model.rd(p, v);
    chk(v, exp);
  endtask

  // bounded wait for the next reading pulse; leaves cnt = cycles waited
  task automatic wait_sample;
    cnt = 0;
    do
    begin
      @(negedge mclk);
      cnt++;
    end
    while (sample !== 1'b1 && cnt < 200);
    if (cnt >= 200)
      chk(16'h0000, 16'h0001);
  endtask

  task automatic step(input logic [12:0] a, input logic e);
    ambient = a;
    wait_sample();
    chk(16'(evt), 16'(e));
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    rst_n   = 1'b0;
    ambient = 13'h0080;
    repeat (4) @(negedge mclk);
    chk(16'(evt), 16'h0001);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h0000);
    rd_chk(thermal_event_pkg::PTR_PRECISION, 16'h0001);
    rd_chk(thermal_event_pkg::PTR_CAPABILITY, 16'h0008);
    u_host_model.wr(8'h05, 16'hffff);
    rd_chk(8'h05, 16'h0000);
    for (int p = 0; p < 4; p++)
    begin
      u_host_model.wr(thermal_event_pkg::PTR_PRECISION, 16'(p));
      rd_chk(thermal_event_pkg::PTR_PRECISION, 16'(p));
      rd_chk(thermal_event_pkg::PTR_CAPABILITY, 16'(p) << 3);
      wait_sample();
      wait_sample();
      wait_sample();
      chk(16'(cnt), 16'(per[p]));
    end
    u_host_model.wr(thermal_event_pkg::PTR_PRECISION, 16'h0000);
    u_host_model.wr(thermal_event_pkg::PTR_ALARM, 16'hffff);
    rd_chk(thermal_event_pkg::PTR_ALARM, 16'h1ffc);
    u_host_model.wr(thermal_event_pkg::PTR_HIGH, 16'h0100);
    u_host_model.wr(thermal_event_pkg::PTR_LOW, 16'h0040);
    u_host_model.wr(thermal_event_pkg::PTR_ALARM, 16'h0200);
    // comparator, 1.5 degree margin, active high
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h020a);
    step(13'h0080, 1'b0);
    step(13'h0110, 1'b1);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h021a);
    step(13'h00f0, 1'b1);
    step(13'h00e0, 1'b0);
    step(13'h0020, 1'b1);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h0200);
    step(13'h0110, 1'b1);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h0208);
    step(13'h0110, 1'b0);
    // 6 degree margin on the high side, then 3 degrees on the low side
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h060a);
    step(13'h00c0, 1'b1);
    step(13'h0090, 1'b0);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h040a);
    step(13'h0020, 1'b0);
    step(13'h0008, 1'b1);
    step(13'h0030, 1'b1);
    step(13'h0040, 1'b0);
    // interrupt mode, no margin; stale flag cleared after the switch
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h000b);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h002b);
    step(13'h0080, 1'b0);
    step(13'h0110, 1'b1);
    step(13'h0080, 1'b1);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h002b);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h000b);
    step(13'h0080, 1'b0);
    step(13'h0200, 1'b1);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h002b);
    step(13'h0200, 1'b1);
    step(13'h0080, 1'b0);
    // alarm-only forces comparator on the alarm limit
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h000f);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h000e);
    step(13'h0110, 1'b0);
    step(13'h0200, 1'b1);
    // shutdown with the event asserted
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h010e);
    chk(16'(sensing_on), 16'h0000);
    ambient = 13'h0080;
    cnt = 0;
    repeat (60)
    begin
      @(negedge mclk);
      if (sample !== 1'b0)
        cnt++;
    end
    chk(16'(cnt), 16'h0000);
    chk(16'(evt), 16'h0001);
    u_host_model.wr(thermal_event_pkg::PTR_PRECISION, 16'h0001);
    rd_chk(thermal_event_pkg::PTR_PRECISION, 16'h0001);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h000e);
    chk(16'(sensing_on), 16'h0001);
    // release only after a full period of running
    cnt = 0;
    while (sample !== 1'b1 && cnt < 200)
    begin
      chk(16'(evt), 16'h0001);
      @(negedge mclk);
      cnt++;
    end
    chk(16'(cnt >= 27 && cnt <= 31), 16'h0001);
    chk(16'(evt), 16'h0000);
    // locks
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h010a);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h01ca);
    chk(16'(sensing_on), 16'h0000);
    u_host_model.wr(thermal_event_pkg::PTR_HIGH, 16'h0040);
    rd_chk(thermal_event_pkg::PTR_HIGH, 16'h0100);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h00ca);
    chk(16'(sensing_on), 16'h0001);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h01ca);
    chk(16'(sensing_on), 16'h0001);
    // a reset in mid-run is the only way to drop the sticky locks
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk(16'(evt), 16'h0001);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h0000);
    // a single lock bit is enough to block limits and shutdown
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h0040);
    u_host_model.wr(thermal_event_pkg::PTR_HIGH, 16'h0040);
    rd_chk(thermal_event_pkg::PTR_HIGH, 16'h0000);
    u_host_model.wr(thermal_event_pkg::PTR_SETUP, 16'h0140);
    chk(16'(sensing_on), 16'h0001);
    rd_chk(thermal_event_pkg::PTR_SETUP, 16'h0040);
    complete_run();
  end

  // a hang costs far more cycles than the whole sequence needs
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    complete_run();
  end
endmodule
